// [hw/cpu_bus_pkg.sv]
// Purpose: Constants and types for the internal bus decoder
// Assumes: 16-bit address space, big-endian word lanes
// Notes: Variant sizes are module parameters
package cpu_bus_pkg;
    // Address map
    localparam logic [15:0] VEC_END = 16'h0029;
    localparam logic [15:0] ROM_END_DEF = 16'h7fff;
    localparam logic [15:0] LCD_BASE0 = 16'hf740;
    localparam logic [15:0] LCD_LAST = 16'h003f;
    localparam logic [15:0] RAM_START_1K = 16'hfb80;
    localparam logic [15:0] RAM_START_2K = 16'hf780;
    localparam logic [15:0] RAM_END = 16'hff7f;
    localparam logic [15:0] RAM_GAP_LO = 16'hfb80;
    localparam logic [15:0] RAM_GAP_HI = 16'hfd7f;
    localparam logic [15:0] SDB_START = 16'hff80;
    localparam logic [15:0] SDB_END = 16'hff9f;
    localparam logic [15:0] IO_START = 16'hffa0;
    localparam logic [15:0] SLOW_LO = 16'hffa8;
    localparam logic [15:0] SLOW_HI = 16'hffad;
    localparam logic [15:0] PLACE_ADDR = 16'hffcf;
    // Placement register layout
    localparam int PLACE_SEL_W = 2;
    localparam logic [5:0] PLACE_RSV = 6'h3f;
    localparam logic [1:0] PLACE_RST = 2'h0;
    // Data filler for undefined bytes
    localparam logic [7:0] UNDEF_BYTE = 8'hff;
    // Exception push offsets from the stack pointer
    localparam logic [15:0] PUSH_PC_OFS = 16'h0002;
    localparam logic [15:0] PUSH_FLAGS_OFS = 16'h0004;
    // State timing
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int SUB_CLK_HZ = 32_768;
    localparam int MED_DIV_DEF = 8;
    localparam int SUB_DIV_DEF = SYS_CLK_HZ / SUB_CLK_HZ;
    localparam int DIV_W = 10;

    typedef enum logic [2:0] {
        MODE_HIGH = 3'b000,
        MODE_MED = 3'b001,
        MODE_SUB = 3'b010,
        MODE_SLEEP = 3'b011,
        MODE_STANDBY = 3'b100,
        MODE_WATCH = 3'b101,
        MODE_SUBSLEEP = 3'b110
    } cpu_mode_t;

    typedef enum logic [2:0] {
        REG_NONE = 3'b000,
        REG_VEC = 3'b001,
        REG_ROM = 3'b010,
        REG_LCD = 3'b011,
        REG_RAM = 3'b100,
        REG_SDB = 3'b101,
        REG_IO = 3'b110,
        REG_PLACE = 3'b111
    } region_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic word;
        logic write;
        logic read;
    } cpu_req_t;

    typedef struct packed {
        region_t sel;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [1:0] be;
        logic we;
        logic re;
    } mem_req_t;

    typedef struct packed {
        logic [15:0] rom;
        logic [15:0] ram;
        logic [15:0] lcd;
        logic [7:0] io;
    } rd_data_t;
endpackage : cpu_bus_pkg

// [hw/cpu_internal_bus_decoder.sv]
// Purpose: Internal bus cycle timing and address decode
// Assumes: One CPU request at a time, strobes one cycle long
// Notes: Halt modes stop the state enable
// Behaviour
// RULE1 - State is one active clock period; cycles 2/3
// RULE2 - ROM/RAM: two states, 16-bit, byte or word
// RULE3 - Peripherals are 8-bit, byte transfers only
// RULE4 - Registers FFA8 to FFAD take three states
// RULE5 - Serial buffer FF80-FF9F, byte, two states
// RULE6 - LCD window F740 after reset, select zero
// RULE7 - Select moves window base in 200h steps
// RULE8 - Placement bits 7..2 read one, unwritable
// RULE9 - 1K RAM, code 11 hides FB80-FD7F
// RULE10 - 2K RAM, nonzero code hides overlapped RAM
// RULE11 - I/O word write keeps only upper byte
// RULE12 - I/O word read: byte high, low undefined
// RULE13 - Unmapped writes dropped, reads undefined
// RULE14 - ROM after vectors to variant end, two states
// RULE15 - RAM ends FF7F, start per variant size
// RULE16 - Active modes system clock, subactive subclock
// RULE17 - Four halt modes stop execution
// RULE18 - Interrupt entry pushes PC and flags
// RULE19 - Vector area is 0000 to 0029
// RULE20 - Three-state access holds CPU one more state
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
module cpu_internal_bus_decoder
    import cpu_bus_pkg::*;
#(
    parameter logic [15:0] ROM_END = ROM_END_DEF,
    parameter bit RAM_2K = 1'b0,
    parameter int MED_DIV = MED_DIV_DEF,
    parameter int SUB_DIV = SUB_DIV_DEF
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire cpu_mode_t cpu_mode_in,
    input wire cpu_req_t cpu_req_in,
    input wire logic exc_req_in,
    input wire logic [15:0] exc_sp_in,
    input wire logic [15:0] exc_pc_in,
    input wire logic [7:0] condition_code_flags_in,
    input wire rd_data_t mem_rd_in,
    output mem_req_t mem_req_out,
    output logic [15:0] cpu_rdata_out,
    output logic cpu_done_out,
    output logic cpu_busy_out,
    output logic exc_done_out,
    output logic state_tick_out,
    output logic halted_out,
    output logic [1:0] lcd_place_sel_out
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_T1 = 2'b01,
        ST_T2 = 2'b10,
        ST_T3 = 2'b11
    } bus_state_t;

    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_lim;
    logic tick_q;
    logic busy_q;
    cpu_req_t pend_q;
    cpu_req_t acc_q;
    cpu_req_t nxt_req;
    region_t nxt_reg;
    region_t reg_q;
    bus_state_t fsm_q;
    logic slow_q;
    logic src_exc_q;
    logic [1:0] exc_step_q;
    logic [1:0] place_q;
    logic start;
    logic fin;
    logic [7:0] rd_byte;
    logic [15:0] rd_word;

    // Address decode against current window placement
    function automatic region_t decode(input logic [15:0] a, input logic [1:0] s);
        logic [15:0] lb;
        logic in_lcd;
        logic ram_ok;
        lb = LCD_BASE0 + {5'h00, s, 9'h000}; // RULE7
        in_lcd = (a >= lb) && (a <= lb + LCD_LAST);
        ram_ok = (a >= (RAM_2K ? RAM_START_2K : RAM_START_1K)) && (a <= RAM_END); // RULE15
        if (!RAM_2K && s == 2'b11 && a >= RAM_GAP_LO && a <= RAM_GAP_HI) begin
            ram_ok = 1'b0; // RULE9
        end
        if (a <= VEC_END) begin
            decode = REG_VEC; // RULE19
        end else if (a <= ROM_END) begin
            decode = REG_ROM; // RULE14
        end else if (in_lcd) begin
            decode = REG_LCD; // RULE10
        end else if (ram_ok) begin
            decode = REG_RAM;
        end else if (a >= SDB_START && a <= SDB_END) begin
            decode = REG_SDB; // RULE5
        end else if (a == PLACE_ADDR) begin
            decode = REG_PLACE;
        end else if (a >= IO_START) begin
            decode = REG_IO;
        end else begin
            decode = REG_NONE; // RULE13
        end
    endfunction : decode

    // State enable from the selected clock
    always_comb begin
        div_lim = (cpu_mode_in == MODE_MED) ? DIV_W'(MED_DIV - 1) : DIV_W'(SUB_DIV - 1);
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            div_q <= '0;
            tick_q <= 1'b0;
            halted_out <= 1'b0;
        end else begin
            unique case (cpu_mode_in)
                MODE_HIGH: begin
                    div_q <= '0;
                    tick_q <= 1'b1; // RULE16
                    halted_out <= 1'b0;
                end
                MODE_MED, MODE_SUB: begin
                    halted_out <= 1'b0;
                    if (div_q >= div_lim) begin
                        div_q <= '0;
                        tick_q <= 1'b1; // RULE1
                    end else begin
                        div_q <= div_q + 1'b1;
                        tick_q <= 1'b0;
                    end
                end
                default: begin
                    div_q <= '0;
                    tick_q <= 1'b0; // RULE17
                    halted_out <= 1'b1;
                end
            endcase
        end
    end

    assign state_tick_out = tick_q;

    // Sequencing conditions
    always_comb begin
        start = tick_q && (fsm_q == ST_IDLE) && ((exc_step_q != 2'b00) || busy_q);
        fin = tick_q && (((fsm_q == ST_T2) && !slow_q) || (fsm_q == ST_T3)); // RULE1
    end

    // Next access, exception pushes first
    always_comb begin
        nxt_req = pend_q;
        if (exc_step_q == 2'b01) begin
            nxt_req.addr = exc_sp_in - PUSH_PC_OFS; // RULE18
            nxt_req.wdata = exc_pc_in;
            nxt_req.word = 1'b1;
            nxt_req.write = 1'b1;
            nxt_req.read = 1'b0;
        end else if (exc_step_q == 2'b10) begin
            nxt_req.addr = exc_sp_in - PUSH_FLAGS_OFS; // RULE18
            nxt_req.wdata = {condition_code_flags_in, 8'h00};
            nxt_req.word = 1'b1;
            nxt_req.write = 1'b1;
            nxt_req.read = 1'b0;
        end
        nxt_reg = decode(nxt_req.addr, place_q);
    end

    // CPU request capture
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            busy_q <= 1'b0;
            pend_q <= '0;
        end else if (!busy_q && (cpu_req_in.read || cpu_req_in.write)) begin
            busy_q <= 1'b1;
            pend_q <= cpu_req_in;
        end else if (fin && !src_exc_q) begin
            busy_q <= 1'b0;
        end
    end

    assign cpu_busy_out = busy_q; // RULE20

    // Exception push steps
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            exc_step_q <= 2'b00;
            exc_done_out <= 1'b0;
        end else begin
            exc_done_out <= 1'b0;
            if (exc_step_q == 2'b00 && exc_req_in && fsm_q == ST_IDLE) begin
                exc_step_q <= 2'b01;
            end else if (fin && src_exc_q) begin
                exc_step_q <= (exc_step_q == 2'b01) ? 2'b10 : 2'b00; // RULE18
                exc_done_out <= (exc_step_q == 2'b10);
            end
        end
    end

    // Bus cycle state machine and memory side request
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            fsm_q <= ST_IDLE;
            acc_q <= '0;
            reg_q <= REG_NONE;
            slow_q <= 1'b0;
            src_exc_q <= 1'b0;
            mem_req_out <= '0;
        end else if (start) begin
            fsm_q <= ST_T1;
            acc_q <= nxt_req;
            reg_q <= nxt_reg;
            src_exc_q <= (exc_step_q != 2'b00);
            slow_q <= (nxt_reg == REG_IO) && (nxt_req.addr >= SLOW_LO)
                && (nxt_req.addr <= SLOW_HI); // RULE4
            mem_req_out.sel <= nxt_reg;
            mem_req_out.addr <= nxt_req.addr;
            unique case (nxt_reg)
                REG_VEC, REG_ROM, REG_LCD, REG_RAM: begin
                    mem_req_out.we <= nxt_req.write && (nxt_reg == REG_LCD || nxt_reg == REG_RAM);
                    mem_req_out.re <= nxt_req.read; // RULE2
                    if (nxt_req.word) begin
                        mem_req_out.be <= 2'b11;
                        mem_req_out.wdata <= nxt_req.wdata;
                    end else begin
                        mem_req_out.be <= nxt_req.addr[0] ? 2'b01 : 2'b10;
                        mem_req_out.wdata <= {nxt_req.wdata[7:0], nxt_req.wdata[7:0]};
                    end
                end
                REG_SDB, REG_IO: begin
                    mem_req_out.we <= nxt_req.write;
                    mem_req_out.re <= nxt_req.read;
                    mem_req_out.be <= 2'b01; // RULE3
                    mem_req_out.wdata <= {8'h00,
                        nxt_req.word ? nxt_req.wdata[15:8] : nxt_req.wdata[7:0]}; // RULE11
                end
                default: begin
                    mem_req_out.we <= 1'b0; // RULE13
                    mem_req_out.re <= 1'b0;
                    mem_req_out.be <= 2'b00;
                    mem_req_out.wdata <= 16'h0000;
                end
            endcase
        end else if (tick_q) begin
            unique case (fsm_q)
                ST_IDLE: fsm_q <= ST_IDLE;
                ST_T1: fsm_q <= ST_T2;
                ST_T2: begin
                    if (slow_q) begin
                        fsm_q <= ST_T3; // RULE20
                    end else begin
                        fsm_q <= ST_IDLE;
                        mem_req_out <= '0;
                    end
                end
                ST_T3: begin
                    fsm_q <= ST_IDLE;
                    mem_req_out <= '0;
                end
            endcase
        end
    end

    // Byte and word data returned to the CPU
    always_comb begin
        unique case (reg_q)
            REG_VEC, REG_ROM: rd_word = mem_rd_in.rom;
            REG_RAM: rd_word = mem_rd_in.ram;
            REG_LCD: rd_word = mem_rd_in.lcd;
            default: rd_word = {UNDEF_BYTE, UNDEF_BYTE};
        endcase
        unique case (reg_q)
            REG_SDB, REG_IO: rd_byte = mem_rd_in.io;
            REG_PLACE: rd_byte = {PLACE_RSV, place_q}; // RULE8
            default: rd_byte = UNDEF_BYTE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            cpu_rdata_out <= 16'h0000;
            cpu_done_out <= 1'b0;
        end else begin
            cpu_done_out <= fin && !src_exc_q;
            if (fin && !src_exc_q && acc_q.read) begin
                unique case (reg_q)
                    REG_VEC, REG_ROM, REG_LCD, REG_RAM: begin
                        if (acc_q.word) begin
                            cpu_rdata_out <= rd_word; // RULE2
                        end else begin
                            cpu_rdata_out <= {8'h00,
                                acc_q.addr[0] ? rd_word[7:0] : rd_word[15:8]};
                        end
                    end
                    REG_NONE: cpu_rdata_out <= {UNDEF_BYTE, UNDEF_BYTE}; // RULE13
                    default: begin
                        if (acc_q.word) begin
                            cpu_rdata_out <= {rd_byte, UNDEF_BYTE}; // RULE12
                        end else begin
                            cpu_rdata_out <= {8'h00, rd_byte};
                        end
                    end
                endcase
            end
        end
    end

    // LCD window placement register
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            place_q <= PLACE_RST; // RULE6
        end else if (fin && reg_q == REG_PLACE && acc_q.write) begin
            place_q <= acc_q.word ? acc_q.wdata[9:8] : acc_q.wdata[PLACE_SEL_W-1:0]; // RULE11
        end
    end

    assign lcd_place_sel_out = place_q;

endmodule : cpu_internal_bus_decoder

// [tb/bus_decoder_asserts.sv]
// Purpose: Port checks for the internal bus decoder
// Assumes: Cycle counts checked in high mode only
// Notes: Bound to every decoder instance
`timescale 1ns/1ns
module bus_decoder_asserts
    import cpu_bus_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire cpu_mode_t cpu_mode_in,
    input wire mem_req_t mem_req_out,
    input wire logic cpu_done_out,
    input wire logic cpu_busy_out,
    input wire logic exc_done_out,
    input wire logic state_tick_out,
    input wire logic halted_out,
    input wire logic [1:0] lcd_place_sel_out
);
    logic act;
    logic slow;
    logic hi;
    logic [15:0] win;
    assign act = mem_req_out.re | mem_req_out.we;
    assign slow = mem_req_out.sel == REG_IO && mem_req_out.addr inside {[SLOW_LO:SLOW_HI]};
    assign hi = cpu_busy_out && cpu_mode_in == MODE_HIGH;
    assign win = LCD_BASE0 + 16'h0200 * lcd_place_sel_out;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    fast_access_a: assert property (
        $rose(act) && hi && !slow |=> !cpu_done_out ##1 cpu_done_out)
        else $error("two-state access length wrong");
    slow_access_a: assert property (
        $rose(act) && hi && slow |=> !cpu_done_out[*2] ##1 cpu_done_out)
        else $error("three-state access length wrong");
    io_lane_a: assert property (act && mem_req_out.sel inside {REG_IO, REG_SDB}
        |-> mem_req_out.be == 2'b01) else $error("peripheral access not on byte lane");
    unmapped_a: assert property (mem_req_out.sel == REG_NONE |-> !act)
        else $error("empty area reached the bus");
    rom_write_a: assert property (mem_req_out.sel inside {REG_VEC, REG_ROM}
        |-> !mem_req_out.we) else $error("write issued to read-only area");
    req_hold_a: assert property (act && $past(act) && hi && $past(cpu_busy_out)
        |-> $stable(mem_req_out)) else $error("request changed during access");
    busy_end_a: assert property ($fell(cpu_busy_out) |-> cpu_done_out)
        else $error("busy dropped without completion");
    place_reset_a: assert property (disable iff (1'b0)
        !rstn_in |=> lcd_place_sel_out == 2'b00 && mem_req_out == '0)
        else $error("reset state wrong");
    halt_idle_a: assert property (halted_out |-> !state_tick_out)
        else $error("state tick while halted");
    high_tick_a: assert property (cpu_mode_in == MODE_HIGH && $past(rstn_in)
        && $past(cpu_mode_in) == MODE_HIGH && $past(cpu_mode_in, 2) == MODE_HIGH
        |-> state_tick_out) else $error("missing tick in high mode");
    lcd_window_a: assert property (act && mem_req_out.addr >= win
        && mem_req_out.addr <= win + LCD_LAST |-> mem_req_out.sel == REG_LCD)
        else $error("access inside window not sent to window");
    cover property ($rose(act) && slow);
    cover property (act && mem_req_out.sel == REG_LCD);
    cover property (exc_done_out);
endmodule : bus_decoder_asserts

bind cpu_internal_bus_decoder bus_decoder_asserts chk (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .cpu_mode_in(cpu_mode_in),
    .mem_req_out(mem_req_out), .cpu_done_out(cpu_done_out), .cpu_busy_out(cpu_busy_out),
    .exc_done_out(exc_done_out), .state_tick_out(state_tick_out),
    .halted_out(halted_out), .lcd_place_sel_out(lcd_place_sel_out));

// [tb/cpu_internal_bus_decoder_test.sv]
// Purpose: Self-checking bench for the internal bus decoder
// Assumes: 1K RAM variant, short state dividers
// Notes: Memory image byte is address low xor high
`timescale 1ns/1ns
module cpu_internal_bus_decoder_test
    import cpu_bus_pkg::*;
;
    logic clk;
    logic rst_n = 0;
    cpu_mode_t mode = MODE_HIGH;
    cpu_req_t req = '0;
    logic exc = 0;
    logic [15:0] sp = '0;
    logic [15:0] pc = '0;
    logic [7:0] flags = '0;
    rd_data_t rd;
    mem_req_t mreq;
    logic [15:0] rdata;
    logic done, busy, edone, tick, halted;
    logic [1:0] psel;
    logic [15:0] q;
    int n;
    int n_fail = 0;
    int compares = 0;
    cpu_internal_bus_decoder #(.RAM_2K(1'b0), .MED_DIV(2), .SUB_DIV(3)) uut (
        .core_clk_in(clk), .rstn_in(rst_n), .cpu_mode_in(mode), .cpu_req_in(req),
        .exc_req_in(exc), .exc_sp_in(sp), .exc_pc_in(pc), .condition_code_flags_in(flags),
        .mem_rd_in(rd), .mem_req_out(mreq), .cpu_rdata_out(rdata), .cpu_done_out(done),
        .cpu_busy_out(busy), .exc_done_out(edone), .state_tick_out(tick),
        .halted_out(halted), .lcd_place_sel_out(psel));
    mem_partner_model mem (.core_clk_in(clk), .mem_req_in(mreq), .mem_rd_out(rd));
    // 2K RAM variant, judged by its bound assertions
    cpu_internal_bus_decoder #(.RAM_2K(1'b1), .MED_DIV(2), .SUB_DIV(3)) uut2 (
        .core_clk_in(clk), .rstn_in(rst_n), .cpu_mode_in(mode), .cpu_req_in(req),
        .exc_req_in(exc), .exc_sp_in(sp), .exc_pc_in(pc), .condition_code_flags_in(flags),
        .mem_rd_in(rd), .mem_req_out(), .cpu_rdata_out(), .cpu_done_out(),
        .cpu_busy_out(), .exc_done_out(), .state_tick_out(),
        .halted_out(), .lcd_place_sel_out());
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    function automatic logic [15:0] f(input logic [15:0] a);
        return {8'h00, a[7:0] ^ a[15:8]};
    endfunction : f
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic [15:0] a, input logic [15:0] d, input logic w, input logic wr);
        n = 0;
        @(posedge clk);
        req <= '{addr: a, wdata: d, word: w, write: wr, read: !wr};
        @(posedge clk);
        req <= '0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (done !== 1'b1 && n < 60);
        q = rdata;
    endtask : acc
    task automatic rchk(input logic [15:0] a, input logic w, input logic [15:0] e, input int st);
        acc(a, 16'h0000, w, 1'b0);
        chk(q, e);
        chk(16'(n), 16'(st + 1));
    endtask : rchk
    task automatic t_place();
        logic [15:0] b;
        chk({14'h0, psel}, 16'h0000);
        rchk(PLACE_ADDR, 0, 16'h00fc, 2);
        for (int c = 3; c >= 0; c--) begin
            acc(PLACE_ADDR, 16'(c), 0, 1);
            rchk(PLACE_ADDR, 0, 16'h00fc | 16'(c), 2);
            chk({14'h0, psel}, 16'(c));
            b = LCD_BASE0 + 16'(c) * 16'h0200;
            rchk(b + 16'h0001, 0, f(b + 16'h0001), 2);
            rchk(b + LCD_LAST, 0, f(b + LCD_LAST), 2);
            if (c != 0) rchk(16'hf741, 0, 16'hffff, 2);
            if (c == 3) rchk(16'hfb90, 0, 16'hffff, 2);
        end
    endtask : t_place
    task automatic t_mem();
        acc(16'hfb80, 16'h1234, 1, 1);
        rchk(16'hfb80, 1, 16'h1234, 2);
        rchk(16'hfb81, 0, 16'h0034, 2);
        rchk(16'hff7f, 0, f(16'hff7f), 2);
        rchk(16'hfb7f, 0, 16'hffff, 2);
        rchk(16'h0000, 1, 16'h0001, 2);
        rchk(16'h002a, 1, 16'h2a2b, 2);
        rchk(ROM_END_DEF - 16'h0001, 1, 16'h8180, 2);
        acc(16'h8000, 16'h0000, 1, 1);
        rchk(16'h8000, 1, 16'hffff, 2);
        chk({8'h00, mem.m[16'h8000]}, f(16'h8000));
        acc(16'hff85, 16'h005a, 0, 1);
        rchk(16'hff85, 0, 16'h005a, 2);
        rchk(SDB_END, 0, f(SDB_END), 2);
    endtask : t_mem
    task automatic t_io();
        logic [15:0] ad [4] = '{16'hffa7, SLOW_LO, SLOW_HI, 16'hffae};
        for (int i = 0; i < 4; i++) begin
            rchk(ad[i], 0, f(ad[i]), (i == 1 || i == 2) ? 3 : 2);
        end
        acc(16'hffa2, 16'hc3d4, 1, 1);
        chk({8'h00, mem.m[16'hffa2]}, 16'h00c3);
        chk({8'h00, mem.m[16'hffa3]}, f(16'hffa3));
        rchk(16'hffa2, 1, 16'hc3ff, 2);
    endtask : t_io
    task automatic t_modes();
        cpu_mode_t hm [4] = '{MODE_SLEEP, MODE_STANDBY, MODE_WATCH, MODE_SUBSLEEP};
        for (int d = 2; d <= 3; d++) begin
            @(posedge clk);
            mode <= (d == 2) ? MODE_MED : MODE_SUB;
            acc(16'hfb80, 16'h0000, 1, 0);
            chk(q, 16'h1234);
            chk(16'(n >= 2 * d && n <= 3 * d + 2), 16'h0001);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            mode <= hm[i];
            repeat (3) @(posedge clk);
            #1 chk({15'h0, halted}, 16'h0001);
        end
        @(posedge clk);
        req <= '{addr: 16'hfb82, wdata: 16'h0000, word: 1'b1, write: 1'b0, read: 1'b1};
        @(posedge clk);
        req <= '0;
        repeat (10) @(posedge clk);
        #1 chk({15'h0, busy}, 16'h0001);
        @(posedge clk);
        mode <= MODE_HIGH;
        n = 0;
        while (done !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        chk({15'h0, done}, 16'h0001);
        chk(rdata, 16'h7978);
        chk({15'h0, halted}, 16'h0000);
    endtask : t_modes
    task automatic t_exc();
        @(posedge clk);
        sp <= 16'hfc00;
        pc <= 16'habcd;
        flags <= 8'ha5;
        exc <= 1'b1;
        @(posedge clk);
        exc <= 1'b0;
        n = 0;
        while (edone !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        chk({15'h0, edone}, 16'h0001);
        chk({mem.m[16'hfbfe], mem.m[16'hfbff]}, 16'habcd);
        chk({mem.m[16'hfbfc], mem.m[16'hfbfd]}, 16'ha500);
    endtask : t_exc
    task automatic complete_run();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        #1 t_place();
        t_mem();
        t_io();
        t_modes();
        t_exc();
        complete_run();
    end
endmodule : cpu_internal_bus_decoder_test

// [tb/mem_partner_model.sv]
// Purpose: On-chip memories and peripheral registers behind the decoder
// Assumes: One flat byte array, big-endian words
// Notes: Idle read lanes toggle every cycle
`timescale 1ns/1ns
module mem_partner_model
    import cpu_bus_pkg::*;
(
    input wire logic core_clk_in,
    input wire mem_req_t mem_req_in,
    output rd_data_t mem_rd_out
);
    logic [7:0] m [0:65535];
    logic [15:0] a;
    logic [15:0] wd;
    logic junk_q;
    assign a = {mem_req_in.addr[15:1], 1'b0};
    assign wd = {m[a], m[a | 16'h0001]};
    assign mem_rd_out = mem_req_in.re ? {wd, wd, wd, m[mem_req_in.addr]} : {56{junk_q}};
    initial begin
        junk_q = 1'b0;
        for (int i = 0; i < 65536; i++) begin
            m[i] = i[7:0] ^ i[15:8];
        end
    end
    always @(posedge core_clk_in) begin
        junk_q <= !junk_q;
        if (mem_req_in.we && mem_req_in.sel inside {REG_IO, REG_SDB}) begin
            m[mem_req_in.addr] <= mem_req_in.wdata[7:0];
        end else if (mem_req_in.we) begin
            if (mem_req_in.be[1]) m[a] <= mem_req_in.wdata[15:8];
            if (mem_req_in.be[0]) m[a | 16'h0001] <= mem_req_in.wdata[7:0];
        end
    end
endmodule : mem_partner_model
